// ---- pfr_chk.sv ----
// Port checker for the stage feedback link.
// Assumes a bind onto pfr_stage; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pfr_chk
    import pfr_pkg::*;
#(
    parameter int SOC_PERIOD_CLKS = 64,
    parameter int DEPTH           = 32
) (
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               reset,
    // Watched ports
    input wire pfr_pkg::pfr_role_t role,
    input wire logic               high_side_drive_pulse,
    input wire logic               phase_current_serial,
    input wire logic               error_conversion_start,
    input wire logic               voltage_error_serial,
    input wire logic               transient_high_trip,
    input wire logic               transient_low_trip,
    input wire logic               ovuv_fault
);
    logic       drv_q;
    logic [4:0] since_q;
    logic       fall;

    // ==========================================
    // Cycles since the last drive fall
    assign fall = drv_q && !high_side_drive_pulse;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drv_q   <= 1'h0;
            since_q <= 5'h1f;
        end else begin
            drv_q   <= high_side_drive_pulse;
            since_q <= fall ? 5'h01 : (since_q == 5'h1f ? since_q : since_q + 5'h01);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ==========================================
    // Assertions
    a_quiet_convert: assert property (fall |=> (!phase_current_serial)[*7])
        else $error("current line not quiet during conversion");
    a_start_bit: assert property ((since_q == 5'h08 || since_q == 5'h09) |-> phase_current_serial)
        else $error("start bit missing");
    a_bit_slot: assert property ((since_q[0] && since_q >= 5'h0b && since_q <= 5'h15)
        |-> $stable(phase_current_serial))
        else $error("current bit shorter than two clocks");
    a_word_ends: assert property (since_q >= 5'h16 |-> !phase_current_serial)
        else $error("current word longer than six bits");
    a_soc_width: assert property ($rose(error_conversion_start)
        |=> error_conversion_start ##1 !error_conversion_start)
        else $error("start pulse not two clocks");
    a_err_frame: assert property ($rose(error_conversion_start) |-> (!voltage_error_serial)[*4]
        ##2 $stable(voltage_error_serial) ##2 $stable(voltage_error_serial)
        ##2 $stable(voltage_error_serial) ##2 $stable(voltage_error_serial)
        ##2 $stable(voltage_error_serial) ##2 $stable(voltage_error_serial)
        ##1 !voltage_error_serial)
        else $error("error word framing wrong");
    a_soc_role: assert property ($rose(error_conversion_start)
        |-> $past(role) == PFR_ROLE_REGULATION)
        else $error("start pulse from non regulation stage");
    a_trip_role: assert property ($past(role) != PFR_ROLE_TRANSIENT
        |-> !transient_high_trip && !transient_low_trip)
        else $error("trip outside transient role");
    a_trip_excl: assert property (!(transient_high_trip && transient_low_trip))
        else $error("both trips at once");
    a_ovuv_role: assert property ($past(role) != PFR_ROLE_OVUV |-> !ovuv_fault)
        else $error("limit fault outside limit role");

    c_fall: cover property (fall);
    c_word: cover property (since_q == 5'h15);
    c_soc: cover property ($rose(error_conversion_start));
    c_trip: cover property (transient_high_trip || transient_low_trip);
endmodule
`default_nettype wire

// ---- pfr_ctl_model.sv ----
// Controller model: decodes current and error words from one stage.
// Assumes the bench drives the drive pulse; same clock as the stage.
`timescale 1ns/1ps
`default_nettype none
module pfr_ctl_model
    import pfr_pkg::*;
(
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Link from the stage, plus the drive pulse from the bench
    input  wire logic         high_side_drive_pulse,
    input  wire logic         phase_current_serial,
    input  wire logic         error_conversion_start,
    input  wire logic         voltage_error_serial,
    input  wire logic         transient_high_trip,
    input  wire logic         transient_low_trip,
    // Decoded results
    output logic [WORD_W-1:0] cur_word,
    output logic              cur_valid,
    output logic [WORD_W-1:0] err_word,
    output logic              err_valid,
    output logic              fast_transient_mode
);
    logic       drv_q;
    logic       soc_q;
    logic [3:0] ccnt_q;
    logic [3:0] ecnt_q;

    // ==========================================
    // Decoders; sample late in each slot for margin
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drv_q <= 1'h0;
            soc_q <= 1'h0;
            ccnt_q <= 4'h0;
            ecnt_q <= 4'h0;
            cur_word <= 6'h00;
            err_word <= 6'h00;
            cur_valid <= 1'h0;
            err_valid <= 1'h0;
            fast_transient_mode <= 1'h0;
        end else begin
            drv_q <= high_side_drive_pulse;
            soc_q <= error_conversion_start;
            cur_valid <= 1'h0;
            err_valid <= 1'h0;
            fast_transient_mode <= transient_high_trip | transient_low_trip;
            if (drv_q && !high_side_drive_pulse) begin
                ccnt_q <= 4'h0;
            end else if (ccnt_q == 4'h0) begin
                ccnt_q <= {3'h0, phase_current_serial};
            end else begin
                ccnt_q <= (ccnt_q == 4'hd) ? 4'h0 : ccnt_q + 4'h1;
                if (ccnt_q[0] && ccnt_q >= 4'h3)
                    cur_word <= {cur_word[4:0], phase_current_serial};
                cur_valid <= (ccnt_q == 4'hd);
            end
            if (error_conversion_start && !soc_q) begin
                ecnt_q <= 4'h1;
            end else if (ecnt_q != 4'h0) begin
                ecnt_q <= (ecnt_q == 4'hf) ? 4'h0 : ecnt_q + 4'h1;
                if (ecnt_q[0] && ecnt_q >= 4'h5)
                    err_word <= {err_word[4:0], voltage_error_serial};
                err_valid <= (ecnt_q == 4'hf);
            end
        end
    end
endmodule
`default_nettype wire

// ---- pfr_fifo.sv ----
// Sample FIFO with registered read data and registered ready.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pfr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             rdy_q, rdy_d, ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, load;

    // ==========================================
    // Next state
    always_comb begin
        push = in_valid & rdy_q;
        // Refill the output register when it is empty or being taken
        load = (cnt_q != CW'(0)) & (~ov_q | out_ready);
        wr_d = push ? AW'(wr_q + AW'(1)) : wr_q;
        rd_d = load ? AW'(rd_q + AW'(1)) : rd_q;
        cnt_d = CW'(cnt_q + CW'(push) - CW'(load));
        ov_d = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d = load ? mem_q[rd_q] : od_q;
        // Ready is registered so back-pressure reaches the source cleanly
        rdy_d = (cnt_d < CW'(DEPTH));
    end

    // ==========================================
    // Registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    // Storage needs no reset
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready  = rdy_q;
    assign out_valid = ov_q;
    assign out_data  = od_q;
endmodule
`default_nettype wire

// ---- pfr_pkg.sv ----
// Shared constants and types for the phase feedback stage model.
// Assumes one clock: the shared stage sample clock, ref_clk.
package pfr_pkg;

    // Word and framing widths
    localparam int WORD_W     = 6;
    localparam int CNT_W      = 4;
    localparam int IDX_W      = 3;
    localparam int OFFS_W     = 4;

    // Stage timing in sample clock cycles
    localparam int CONV_BIT_CLKS = 6;
    localparam int LOAD_CLKS     = 1;
    localparam int CONV_CLKS     = CONV_BIT_CLKS + LOAD_CLKS;
    localparam int BIT_CLKS      = 2;
    localparam int SOC_CLKS      = 2;
    localparam int SOC_GAP_CLKS  = 2;
    localparam int SOC_PERIOD    = 64;

    // Buffer shape
    localparam int FIFO_DEPTH = 32;

    // Fixed codes
    localparam logic [CNT_W-1:0]  CNT_ZERO = 4'h0;
    localparam logic [IDX_W-1:0]  IDX_ZERO = 3'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 6'h00;

    // Role given to a stage by the controller
    typedef enum logic [1:0] {
        PFR_ROLE_PLAIN,
        PFR_ROLE_REGULATION,
        PFR_ROLE_TRANSIENT,
        PFR_ROLE_OVUV
    } pfr_role_t;

    // One analog snapshot to be reported
    typedef struct packed {
        logic [WORD_W-1:0] current;
        logic [WORD_W-1:0] verr;
    } pfr_sample_t;

    // Window comparator settings
    typedef struct packed {
        logic [OFFS_W-1:0] trip_high;
        logic [OFFS_W-1:0] trip_low;
        logic [WORD_W-1:0] ovuv_limit;
    } pfr_window_t;

    localparam int SAMPLE_W = $bits(pfr_sample_t);

endpackage

// ---- pfr_stage.sv ----
// Power stage end of the phase feedback link: current words, error words,
// window comparator trips. Assumes the controller supplies the shared
// sample clock as ref_clk and samples these serial lines on it.
//
// Functional notes
// - Drive pulse falling edge starts current conversion
// - Six bit clocks plus one load clock
// - Start bit precedes each current word
// - Six current bits follow, MSB first
// - Each serial bit lasts two clocks
// - Drive pulse glitch restarts current conversion
// - Every stage returns current words, any role
// - Regulation stage pulses start two clocks
// - Six error bits, two clocks after start
// - Error converter resolves bit per two clocks
// - Trip and limit stages use window comparator
`timescale 1ns/1ps
`default_nettype none
module pfr_stage
    import pfr_pkg::*;
#(
    parameter int SOC_PERIOD_CLKS = pfr_pkg::SOC_PERIOD,
    parameter int DEPTH           = pfr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // Sample source
    input  wire logic                 sample_valid,
    output logic                      sample_ready,
    input  wire pfr_pkg::pfr_sample_t sample_data,
    // Configuration from the controller
    input  wire pfr_pkg::pfr_role_t   role,
    input  wire pfr_pkg::pfr_window_t window,
    // Link from the controller
    input  wire logic                 high_side_drive_pulse,
    // Link to the controller
    output logic                      phase_current_serial,
    output logic                      error_conversion_start,
    output logic                      voltage_error_serial,
    output logic                      transient_high_trip,
    output logic                      transient_low_trip,
    output logic                      ovuv_fault
);
    import pfr_pkg::*;

    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CLKS - 1);
    localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CLKS - 1);
    localparam logic [CNT_W-1:0] SOC_LAST  = CNT_W'(SOC_CLKS - 1);
    localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(SOC_GAP_CLKS - 1);
    localparam logic [IDX_W-1:0] MSB_IDX   = IDX_W'(WORD_W - 1);
    localparam int               PER_W     = $clog2(SOC_PERIOD_CLKS + 1);
    localparam logic [PER_W-1:0] PER_LAST  = PER_W'(SOC_PERIOD_CLKS - 1);

    typedef enum logic [1:0] {C_IDLE, C_CONV, C_START, C_DATA} pfr_cstate_t;
    typedef enum logic [1:0] {V_IDLE, V_SOC, V_GAP, V_DATA} pfr_vstate_t;

    // ==========================================
    // Sample buffer
    logic        fifo_valid;
    logic        fifo_pop;
    pfr_sample_t fifo_data;

    pfr_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // Shift word out MSB first
    function automatic logic [WORD_W-1:0] shift_up(input logic [WORD_W-1:0] w);
        shift_up = {w[WORD_W-2:0], 1'b0};
    endfunction

    // ==========================================
    // Current word engine
    pfr_cstate_t       cst_q, cst_d;
    logic [CNT_W-1:0]  ccnt_q, ccnt_d;
    logic [IDX_W-1:0]  cidx_q, cidx_d;
    logic [WORD_W-1:0] csh_q, csh_d;
    logic              cser_q, cser_d;
    logic              drv_q;
    pfr_sample_t       held_q, held_d;
    logic              fall;

    always_comb begin
        // Inputs are synchronous; the registered edge adds the alignment clock
        fall     = drv_q & ~high_side_drive_pulse;
        fifo_pop = fall & fifo_valid;
        held_d   = fifo_pop ? fifo_data : held_q;
        cst_d    = cst_q;
        ccnt_d   = ccnt_q;
        cidx_d   = cidx_q;
        csh_d    = csh_q;
        cser_d   = cser_q;
        if (fall) begin
            // A new edge aborts whatever word is in flight
            cst_d  = C_CONV;
            ccnt_d = CONV_LAST;
            csh_d  = held_d.current;
            cser_d = 1'b0;
        end else begin
            unique case (cst_q)
                C_IDLE: begin
                    cser_d = 1'b0;
                end
                C_CONV: begin
                    if (ccnt_q == CNT_ZERO) begin
                        cst_d  = C_START;
                        ccnt_d = BIT_LAST;
                        cser_d = 1'b1;
                    end else begin
                        ccnt_d = ccnt_q - CNT_W'(1);
                    end
                end
                C_START: begin
                    if (ccnt_q == CNT_ZERO) begin
                        cst_d  = C_DATA;
                        ccnt_d = BIT_LAST;
                        cidx_d = MSB_IDX;
                        cser_d = csh_q[WORD_W-1];
                    end else begin
                        ccnt_d = ccnt_q - CNT_W'(1);
                    end
                end
                C_DATA: begin
                    if (ccnt_q != CNT_ZERO) begin
                        ccnt_d = ccnt_q - CNT_W'(1);
                    end else if (cidx_q == IDX_ZERO) begin
                        cst_d  = C_IDLE;
                        cser_d = 1'b0;
                    end else begin
                        ccnt_d = BIT_LAST;
                        cidx_d = cidx_q - IDX_W'(1);
                        csh_d  = shift_up(csh_q);
                        cser_d = csh_q[WORD_W-2];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cst_q  <= C_IDLE;
            ccnt_q <= CNT_ZERO;
            cidx_q <= IDX_ZERO;
            csh_q  <= WORD_ZERO;
            cser_q <= 1'b0;
            drv_q  <= 1'b0;
            held_q <= '0;
        end else begin
            cst_q  <= cst_d;
            ccnt_q <= ccnt_d;
            cidx_q <= cidx_d;
            csh_q  <= csh_d;
            cser_q <= cser_d;
            drv_q  <= high_side_drive_pulse;
            held_q <= held_d;
        end
    end

    // ==========================================
    // Voltage error engine, regulation role only
    pfr_vstate_t       vst_q, vst_d;
    logic [CNT_W-1:0]  vcnt_q, vcnt_d;
    logic [IDX_W-1:0]  vidx_q, vidx_d;
    logic [WORD_W-1:0] vsh_q, vsh_d;
    logic              vser_q, vser_d;
    logic              soc_q, soc_d;
    logic [PER_W-1:0]  per_q, per_d;

    always_comb begin
        vst_d  = vst_q;
        vcnt_d = vcnt_q;
        vidx_d = vidx_q;
        vsh_d  = vsh_q;
        vser_d = vser_q;
        soc_d  = soc_q;
        per_d  = (per_q == PER_W'(0)) ? PER_LAST : per_q - PER_W'(1);
        unique case (vst_q)
            V_IDLE: begin
                vser_d = 1'b0;
                // Role change takes effect at the next conversion
                if (per_q == PER_W'(0) && role == PFR_ROLE_REGULATION) begin
                    vst_d  = V_SOC;
                    vcnt_d = SOC_LAST;
                    soc_d  = 1'b1;
                    vsh_d  = held_q.verr;
                end
            end
            V_SOC: begin
                if (vcnt_q == CNT_ZERO) begin
                    vst_d  = V_GAP;
                    vcnt_d = GAP_LAST;
                    soc_d  = 1'b0;
                end else begin
                    vcnt_d = vcnt_q - CNT_W'(1);
                end
            end
            V_GAP: begin
                if (vcnt_q == CNT_ZERO) begin
                    vst_d  = V_DATA;
                    vcnt_d = BIT_LAST;
                    vidx_d = MSB_IDX;
                    vser_d = vsh_q[WORD_W-1];
                end else begin
                    vcnt_d = vcnt_q - CNT_W'(1);
                end
            end
            V_DATA: begin
                if (vcnt_q != CNT_ZERO) begin
                    vcnt_d = vcnt_q - CNT_W'(1);
                end else if (vidx_q == IDX_ZERO) begin
                    vst_d  = V_IDLE;
                    vser_d = 1'b0;
                end else begin
                    vcnt_d = BIT_LAST;
                    vidx_d = vidx_q - IDX_W'(1);
                    vsh_d  = shift_up(vsh_q);
                    vser_d = vsh_q[WORD_W-2];
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            vst_q  <= V_IDLE;
            vcnt_q <= CNT_ZERO;
            vidx_q <= IDX_ZERO;
            vsh_q  <= WORD_ZERO;
            vser_q <= 1'b0;
            soc_q  <= 1'b0;
            per_q  <= PER_LAST;
        end else begin
            vst_q  <= vst_d;
            vcnt_q <= vcnt_d;
            vidx_q <= vidx_d;
            vsh_q  <= vsh_d;
            vser_q <= vser_d;
            soc_q  <= soc_d;
            per_q  <= per_d;
        end
    end

    // ==========================================
    // Window comparator on the held error sample
    logic signed [WORD_W-1:0] err_s, hi_lim, lo_lim;
    // One bit wider so limits above mid-scale stay positive
    logic signed [WORD_W:0]   err_x, ov_hi, ov_lo;
    logic                     thi_q, thi_d, tlo_q, tlo_d, ovf_q, ovf_d;

    always_comb begin
        err_s  = held_q.verr;
        hi_lim = {2'b00, window.trip_high};
        lo_lim = WORD_ZERO - {2'b00, window.trip_low};
        err_x  = {err_s[WORD_W-1], err_s};
        ov_hi  = {1'b0, window.ovuv_limit};
        ov_lo  = -ov_hi;
        thi_d  = (role == PFR_ROLE_TRANSIENT) && (err_s > hi_lim);
        tlo_d  = (role == PFR_ROLE_TRANSIENT) && (err_s < lo_lim);
        ovf_d  = (role == PFR_ROLE_OVUV) && (err_x > ov_hi || err_x < ov_lo);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            thi_q <= 1'b0;
            tlo_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            thi_q <= thi_d;
            tlo_q <= tlo_d;
            ovf_q <= ovf_d;
        end
    end

    assign phase_current_serial   = cser_q;
    assign error_conversion_start = soc_q;
    assign voltage_error_serial   = vser_q;
    assign transient_high_trip    = thi_q;
    assign transient_low_trip     = tlo_q;
    assign ovuv_fault             = ovf_q;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the stage feedback link.
// Assumes pfr_stage, pfr_ctl_model and pfr_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pfr_pkg::*;
    localparam int DEPTH_T = 8;
    localparam int SOC_T   = 32;
    logic        ref_clk = 1'h0;
    logic        reset = 1'h1;
    logic        sample_valid = 1'h0;
    logic        sample_ready;
    pfr_sample_t sample_data = '0;
    pfr_role_t   role = PFR_ROLE_PLAIN;
    pfr_window_t window = '0;
    logic        drive = 1'h0;
    logic        cur_ser, soc, err_ser, trip_h, trip_l, ovuv;
    logic [5:0]  cur_word, err_word;
    logic        cur_valid, err_valid, ftm;
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          nwords = 0;
    int          n0;
    int          seed = 73461;
    pfr_sample_t exp_q[$];
    pfr_sample_t last;

    pfr_stage #(.SOC_PERIOD_CLKS(SOC_T), .DEPTH(DEPTH_T)) pfr_stage_i (
        .ref_clk(ref_clk), .reset(reset), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_data(sample_data), .role(role),
        .window(window), .high_side_drive_pulse(drive), .phase_current_serial(cur_ser),
        .error_conversion_start(soc), .voltage_error_serial(err_ser),
        .transient_high_trip(trip_h), .transient_low_trip(trip_l), .ovuv_fault(ovuv));

    pfr_ctl_model pfr_ctl_model_i (
        .ref_clk(ref_clk), .reset(reset), .high_side_drive_pulse(drive),
        .phase_current_serial(cur_ser), .error_conversion_start(soc),
        .voltage_error_serial(err_ser), .transient_high_trip(trip_h),
        .transient_low_trip(trip_l), .cur_word(cur_word), .cur_valid(cur_valid),
        .err_word(err_word), .err_valid(err_valid), .fast_transient_mode(ftm));

    // ==========================================
    // Clock, cycle limit, word counter
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cur_valid === 1'h1)
            nwords <= nwords + 1;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end

    // ==========================================
    // Helpers
    function automatic logic [2:0] trips(input pfr_role_t r, input pfr_window_t w,
                                         input logic [5:0] v);
        int s;
        s = $signed(v);
        trips[2] = (r == PFR_ROLE_TRANSIENT) && (s > int'(w.trip_high));
        trips[1] = (r == PFR_ROLE_TRANSIENT) && (s < -int'(w.trip_low));
        trips[0] = (r == PFR_ROLE_OVUV) && ((s < 0 ? -s : s) > int'(w.ovuv_limit));
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic fall_drive(input int hi);
        drive <= 1'h1;
        repeat (hi) @(posedge ref_clk);
        drive <= 1'h0;
        @(posedge ref_clk);
    endtask

    // Bounded wait; a missing word shows as a valid mismatch
    task automatic wait_word(input logic is_err, input logic [5:0] e);
        int k;
        k = 0;
        while ((is_err ? err_valid : cur_valid) !== 1'h1 && k < 80) begin
            @(posedge ref_clk);
            k++;
        end
        chk("word valid", 8'h01, {7'h0, is_err ? err_valid : cur_valid});
        chk("word value", {2'h0, e}, {2'h0, is_err ? err_word : cur_word});
        @(posedge ref_clk);
    endtask

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'h0;
        repeat (3) @(posedge ref_clk);
        chk("ready after reset", 8'h01, {7'h0, sample_ready});
        chk("lines idle", 8'h00, {5'h0, cur_ser, soc, err_ser});
        sample_valid <= 1'h1;
        sample_data <= pfr_sample_t'(12'($random(seed)));
        for (int k = 0; k < 6; k++) begin
            @(posedge ref_clk);
            if (sample_ready === 1'h1) begin
                exp_q.push_back(sample_data);
                sample_data <= pfr_sample_t'(12'($random(seed)));
                k = -1;
            end
        end
        sample_valid <= 1'h0;
        chk("words held", 8'(DEPTH_T + 1), 8'(exp_q.size()));
        while (exp_q.size() > 0) begin
            last = exp_q.pop_front();
            role <= pfr_role_t'(2'(exp_q.size()));
            window <= pfr_window_t'(14'($random(seed)));
            fall_drive(1 + ($random(seed) & 3));
            wait_word(1'h0, last.current);
            chk("trips", {5'h0, trips(role, window, last.verr)}, {5'h0, trip_h, trip_l, ovuv});
            chk("transient mode", {7'h0, trips(role, window, last.verr) >= 3'h2}, {7'h0, ftm});
            if (role == PFR_ROLE_REGULATION)
                wait_word(1'h1, last.verr);
        end
        // Empty buffer: held sample is sent again
        fall_drive(2);
        wait_word(1'h0, last.current);
        sample_valid <= 1'h1;
        sample_data <= pfr_sample_t'(12'($random(seed)));
        @(posedge ref_clk);
        last = sample_data;
        sample_valid <= 1'h0;
        repeat (3) @(posedge ref_clk);
        fall_drive(2);
        repeat (12) @(posedge ref_clk);
        n0 = nwords;
        fall_drive(2);
        wait_word(1'h0, last.current);
        repeat (30) @(posedge ref_clk);
        chk("words after glitch", 8'h01, 8'(nwords - n0));
        print_verdict();
    end
endmodule

bind pfr_stage pfr_chk #(.SOC_PERIOD_CLKS(SOC_PERIOD_CLKS), .DEPTH(DEPTH)) pfr_chk_i (
    .ref_clk(ref_clk), .reset(reset), .role(role),
    .high_side_drive_pulse(high_side_drive_pulse), .phase_current_serial(phase_current_serial),
    .error_conversion_start(error_conversion_start), .voltage_error_serial(voltage_error_serial),
    .transient_high_trip(transient_high_trip), .transient_low_trip(transient_low_trip),
    .ovuv_fault(ovuv_fault));
`default_nettype wire
